// *** rtl/scr_pkg.sv ***
package scr_pkg;

  localparam int ADDR_W = 12;
  localparam logic [9:0] OPT_IDX = 10'h039;
  localparam logic [9:0] CFG_IDX = 10'h03F;
  localparam logic [9:0] STAT_IDX = 10'h030;
  localparam logic [9:0] PROG_IDX = 10'h031;

  localparam logic [7:0] OPT_RESET = 8'h10;
  localparam logic [7:0] CFG_RESET = 8'h60;
  localparam logic [7:0] CFG_UNUSED_MASK = 8'h60;
  localparam logic [7:0] OPT_PROT_MASK = 8'h37;
  localparam logic [7:0] OPT_FORCE_MASK = 8'h04;

  localparam int OPT_PWR_BIT = 7;
  localparam int OPT_CLKSEL_BIT = 6;
  localparam int OPT_EDGE_BIT = 5;
  localparam int OPT_DELAY_BIT = 4;
  localparam int OPT_MON_BIT = 3;
  localparam int OPT_FORCE_BIT = 2;
  localparam int OPT_CR_LSB = 0;
  localparam int CFG_PLACE_BIT = 7;
  localparam int CFG_PULLUP_BIT = 4;
  localparam int CFG_UNSECURE_BIT = 3;
  localparam int CFG_WDG_OFF_BIT = 2;
  localparam int CFG_ROM_BIT = 1;
  localparam int CFG_NVM_BIT = 0;

  localparam logic [6:0] WIN_CYC = 7'h40;
  localparam int STOP_DLY_E_CYC = 4000;
  localparam logic [11:0] STOP_DLY_CNT = 12'(STOP_DLY_E_CYC - 1);
  localparam int WDG_PRE_BITS = 15;

  localparam logic [1:0] CAUSE_PIN = 2'h0;
  localparam logic [1:0] CAUSE_CLKMON = 2'h1;
  localparam logic [1:0] CAUSE_WDG = 2'h2;
  localparam logic [7:0] VEC_NORMAL_HI = 8'hFF;
  localparam logic [7:0] VEC_SPECIAL_HI = 8'hBF;
  localparam logic [7:0] VEC_LO_PIN = 8'hFE;
  localparam logic [7:0] VEC_LO_CLKMON = 8'hFC;
  localparam logic [7:0] VEC_LO_WDG = 8'hFA;

  typedef enum logic [2:0] {ST_SETTLE0, ST_SETTLE1, ST_LOAD, ST_FETCH_HI, ST_FETCH_LO, ST_RUN} scr_fsm_t;

  typedef struct packed {
    logic converter_power;
    logic clock_source_select;
    logic interrupt_edge_select;
    logic clock_monitor_on;
    logic rom_placement;
    logic pullup_register_enable;
    logic security_disable;
    logic watchdog_enable;
    logic rom_enable;
    logic nvm_enable;
    logic special_mode_bit;
  } scr_ctrl_t;

  typedef struct packed {
    scr_fsm_t st;
    logic [6:0] win_cnt;
    logic opt_locked;
    logic [7:0] opt;
    logic [7:0] cfg;
    logic [1:0] cause;
    logic mode_s1;
    logic mode_s2;
    logic [1:0] cause_s1;
    logic [1:0] cause_s2;
    logic [15:0] vec;
    logic fetch;
    logic ccr_x;
    logic ccr_i;
    logic ccr_s;
    logic [20:0] wdg_cnt;
    logic wdg_tick;
    logic [11:0] stop_cnt;
    logic stop_busy;
    logic stop_done;
    logic [7:0] prog_data;
    logic prog_strobe;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    scr_ctrl_t ctrl;
  } scr_regs_t;

endpackage

// *** rtl/scr_top.sv ***
// Behaviour
// - Protected option bits take one write within 64 cycles of reset, then lock.
// - In special mode the protected option bits are writable at any time.
// - Options register resets to 0x10, only the stop delay bit set.
// - Converter power bit enables the analog converter when set.
// - Clock select bit picks the internal RC clock for converter and memory.
// - Interrupt edge bit selects falling edge, else low level sensing.
// - Stop delay bit imposes about 4000 cycles on stop recovery, else none.
// - Clock monitor enable is freely read and written and cleared by reset.
// - Forced monitor keeps clock monitor on until the next reset.
// - Watchdog rate scales the bus clock after a divide by two to fifteen.
// - Config reads return latches loaded at the last reset or by a later special mode write.
// - Config bits 6 and 5 always read as one.
// - In special mode config bits are directly writable.
// - In normal mode config changes only through programming and the next reset.
// - ROM placement bit maps ROM high when set, low when clear.
// - Pull-up enable bit gates the pull-up assignment register.
// - Security disable bit turns off memory protection when set.
// - Watchdog disable bit stops the watchdog, else the watchdog runs.
// - ROM and memory enable bits place each memory in the map.
// - Normal mode vectors are FFFE, FFFC and FFFA by reset cause.
// - Special mode vectors are BFFE, BFFC and BFFA by reset cause.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module scr_top
  import scr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode_pin,
  input wire logic [1:0] reset_cause_pin,
  input wire logic [7:0] nvm_cells,
  input wire logic stop_exit,
  input wire logic cpu_ccr_release,
  output scr_ctrl_t ctrl,
  output logic watchdog_tick,
  output logic stop_recovered,
  output logic [15:0] restart_vector,
  output logic vector_fetch,
  output logic ccr_x_mask,
  output logic ccr_i_mask,
  output logic ccr_s_bit,
  output logic [7:0] nvm_prog_data,
  output logic nvm_prog_strobe
);

  scr_regs_t r;
  scr_regs_t n;
  logic setup;
  logic wr_en;
  logic [9:0] idx;
  logic win_open;

  function automatic logic [15:0] vec_of(input logic special, input logic [1:0] cause);
    logic [7:0] lo;
    lo = VEC_LO_PIN;
    if (cause == CAUSE_CLKMON) begin
      lo = VEC_LO_CLKMON;
    end else if (cause == CAUSE_WDG) begin
      lo = VEC_LO_WDG;
    end
    return {special ? VEC_SPECIAL_HI : VEC_NORMAL_HI, lo};
  endfunction

  function automatic logic wdg_due(input logic [20:0] cnt, input logic [1:0] rate);
    logic [21:0] m;
    m = (22'h1 << (WDG_PRE_BITS + 2 * int'(rate))) - 22'h1;
    return (cnt & m[20:0]) == m[20:0];
  endfunction

  assign setup = psel && !penable;
  assign wr_en = psel && penable && r.pready && pwrite && pstrb[0] && !r.pslverr;
  assign idx = paddr[ADDR_W-1:2];
  assign win_open = (r.win_cnt < WIN_CYC) && !r.opt_locked;

  always_comb begin
    n = r;
    n.mode_s1 = special_mode_pin;
    n.mode_s2 = r.mode_s1;
    n.cause_s1 = reset_cause_pin;
    n.cause_s2 = r.cause_s1;
    n.pready = setup;
    n.prog_strobe = 1'b0;
    n.wdg_tick = 1'b0;
    n.stop_done = 1'b0;
    if (r.win_cnt < WIN_CYC) begin
      n.win_cnt = r.win_cnt + 7'h01;
    end

    // Read data and the error answer are settled in the setup cycle, so the access phase needs no wait.
    if (setup) begin
      n.pslverr = (paddr[1:0] != 2'h0) ||
                  !(idx == OPT_IDX || idx == CFG_IDX || idx == STAT_IDX || idx == PROG_IDX);
      n.prdata = 32'h0;
      if (idx == OPT_IDX) begin
        n.prdata[7:0] = r.opt;
      end else if (idx == CFG_IDX) begin
        n.prdata[7:0] = r.cfg | CFG_UNUSED_MASK;
      end else if (idx == STAT_IDX) begin
        n.prdata[7:0] = {r.ctrl.watchdog_enable, r.ctrl.clock_monitor_on, r.stop_busy,
                         r.st == ST_RUN, win_open, r.cause, r.ctrl.special_mode_bit};
      end else if (idx == PROG_IDX) begin
        n.prdata[7:0] = r.prog_data;
      end
    end

    if (wr_en && idx == OPT_IDX) begin
      if (r.ctrl.special_mode_bit || win_open) begin
        n.opt = pwdata[7:0];
      end else begin
        n.opt = (r.opt & OPT_PROT_MASK) | (pwdata[7:0] & ~OPT_PROT_MASK);
      end
      // A forced monitor once set cannot be dropped, even by a special mode write.
      n.opt = n.opt | (r.opt & OPT_FORCE_MASK);
      if (!r.ctrl.special_mode_bit) begin
        n.opt_locked = 1'b1;
      end
    end

    if (wr_en && idx == CFG_IDX && r.ctrl.special_mode_bit) begin
      n.cfg = pwdata[7:0] | CFG_UNUSED_MASK;
    end

    // In normal mode the byte goes to the nonvolatile cells only and waits for the next reset.
    if (wr_en && idx == PROG_IDX) begin
      n.prog_data = pwdata[7:0];
      n.prog_strobe = 1'b1;
    end

    unique case (r.st)
      ST_SETTLE0: n.st = ST_SETTLE1;
      ST_SETTLE1: n.st = ST_LOAD;
      ST_LOAD: begin
        n.st = ST_FETCH_HI;
        n.ctrl.special_mode_bit = r.mode_s2;
        n.cause = r.cause_s2;
        n.cfg = nvm_cells | CFG_UNUSED_MASK;
        n.vec = vec_of(r.mode_s2, r.cause_s2);
        n.fetch = 1'b1;
      end
      ST_FETCH_HI: begin
        n.st = ST_FETCH_LO;
        n.vec = r.vec + 16'h0001;
      end
      ST_FETCH_LO: begin
        n.st = ST_RUN;
        n.fetch = 1'b0;
      end
      ST_RUN: begin
        if (cpu_ccr_release) begin
          n.ccr_x = 1'b0;
          n.ccr_i = 1'b0;
          n.ccr_s = 1'b0;
        end
      end
    endcase

    // The prescaler and rate divider share one counter, so a rate change takes effect on the next count, without waiting for a wrap.
    if (r.st == ST_RUN && r.ctrl.watchdog_enable) begin
      n.wdg_cnt = r.wdg_cnt + 21'h000001;
      n.wdg_tick = wdg_due(r.wdg_cnt, r.opt[OPT_CR_LSB +: 2]);
    end else begin
      n.wdg_cnt = 21'h0;
    end

    if (r.stop_busy) begin
      if (r.stop_cnt == 12'h0) begin
        n.stop_busy = 1'b0;
        n.stop_done = 1'b1;
      end else begin
        n.stop_cnt = r.stop_cnt - 12'h001;
      end
    end else if (stop_exit) begin
      if (r.opt[OPT_DELAY_BIT]) begin
        n.stop_busy = 1'b1;
        n.stop_cnt = STOP_DLY_CNT;
      end else begin
        n.stop_done = 1'b1;
      end
    end

    n.ctrl.converter_power = n.opt[OPT_PWR_BIT];
    n.ctrl.clock_source_select = n.opt[OPT_CLKSEL_BIT];
    n.ctrl.interrupt_edge_select = n.opt[OPT_EDGE_BIT];
    n.ctrl.clock_monitor_on = n.opt[OPT_MON_BIT] | n.opt[OPT_FORCE_BIT];
    n.ctrl.rom_placement = n.cfg[CFG_PLACE_BIT];
    n.ctrl.pullup_register_enable = n.cfg[CFG_PULLUP_BIT];
    n.ctrl.security_disable = n.cfg[CFG_UNSECURE_BIT];
    n.ctrl.watchdog_enable = !n.cfg[CFG_WDG_OFF_BIT];
    n.ctrl.rom_enable = n.cfg[CFG_ROM_BIT];
    n.ctrl.nvm_enable = n.cfg[CFG_NVM_BIT];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.opt <= OPT_RESET;
      r.cfg <= CFG_RESET;
      r.ccr_x <= 1'b1;
      r.ccr_i <= 1'b1;
      r.ccr_s <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign ctrl = r.ctrl;
  assign watchdog_tick = r.wdg_tick;
  assign stop_recovered = r.stop_done;
  assign restart_vector = r.vec;
  assign vector_fetch = r.fetch;
  assign ccr_x_mask = r.ccr_x;
  assign ccr_i_mask = r.ccr_i;
  assign ccr_s_bit = r.ccr_s;
  assign nvm_prog_data = r.prog_data;
  assign nvm_prog_strobe = r.prog_strobe;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  chk_opt_lock: assert property (
    wr_en && idx == OPT_IDX && !r.ctrl.special_mode_bit && !win_open
    |=> (r.opt & OPT_PROT_MASK) == ($past(r.opt) & OPT_PROT_MASK))
    else $error("Protected option bits changed after the write window closed.");

  chk_special_write: assert property (
    wr_en && idx == OPT_IDX && r.ctrl.special_mode_bit
    |=> (r.opt & ~OPT_FORCE_MASK) == ($past(pwdata[7:0]) & ~OPT_FORCE_MASK))
    else $error("Special mode write to the options register was not taken.");

  chk_cfg_frozen: assert property (
    wr_en && idx == CFG_IDX && !r.ctrl.special_mode_bit && r.st == ST_RUN |=> $stable(r.cfg))
    else $error("Config latches changed by a normal mode write.");

  chk_cfg_ones: assert property (
    psel && penable && pready && !pwrite && idx == CFG_IDX |-> prdata[6:5] == 2'b11)
    else $error("Config bits 6 and 5 did not read as one.");

  chk_force_hold: assert property (
    r.opt[OPT_FORCE_BIT] |=> r.opt[OPT_FORCE_BIT] && ctrl.clock_monitor_on)
    else $error("Forced clock monitor dropped before reset.");

  chk_vec_sel: assert property (
    r.st == ST_LOAD |=> vector_fetch && restart_vector == vec_of($past(r.mode_s2), $past(r.cause_s2))
    ##1 vector_fetch && restart_vector[0] ##1 !vector_fetch)
    else $error("Restart vector pair fetched from the wrong address.");

  chk_stop_delay: assert property (
    stop_exit && !r.stop_busy && r.opt[OPT_DELAY_BIT] |=> !stop_recovered [*8])
    else $error("Stop recovery finished without the start-up delay.");

  chk_stop_bypass: assert property (
    stop_exit && !r.stop_busy && !r.opt[OPT_DELAY_BIT] |=> stop_recovered)
    else $error("Stop recovery delayed although the delay is bypassed.");

  chk_ccr_masks: assert property (
    r.st != ST_RUN |-> ccr_x_mask && ccr_i_mask && ccr_s_bit)
    else $error("Condition code masks not set before the core runs.");

  chk_wdg_rate: assert property (
    watchdog_tick |-> $past(r.wdg_cnt[WDG_PRE_BITS-1:0]) == 15'h7FFF)
    else $error("Watchdog tick not aligned to the prescaler wrap.");

  chk_wdg_off: assert property (
    r.cfg[CFG_WDG_OFF_BIT] [*2] |-> !watchdog_tick)
    else $error("Watchdog ticked while disabled.");

endmodule

`default_nettype wire

// *** tb/system_config_reset_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module system_config_reset_control_tb
  import scr_pkg::*;
;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic special_mode_pin = 0, stop_exit = 0, cpu_ccr_release = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [1:0] reset_cause_pin = 2'h0;
  logic [7:0] nvm_cells = 8'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, watchdog_tick, stop_recovered, vector_fetch, err;
  logic ccr_x_mask, ccr_i_mask, ccr_s_bit, nvm_prog_strobe;
  scr_ctrl_t ctrl;
  logic [15:0] restart_vector;
  logic [7:0] nvm_prog_data, d;
  logic [7:0] lo_t [3] = '{8'hFE, 8'hFC, 8'hFA};
  int fails = 0, check_count = 0, seed = 42332, cyc = 0, opt_m, cfg_m, n;
  bit smode, lock;

  scr_top dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode_pin(special_mode_pin), .reset_cause_pin(reset_cause_pin), .nvm_cells(nvm_cells),
    .stop_exit(stop_exit), .cpu_ccr_release(cpu_ccr_release), .ctrl(ctrl), .watchdog_tick(watchdog_tick),
    .stop_recovered(stop_recovered), .restart_vector(restart_vector), .vector_fetch(vector_fetch),
    .ccr_x_mask(ccr_x_mask), .ccr_i_mask(ccr_i_mask), .ccr_s_bit(ccr_s_bit),
    .nvm_prog_data(nvm_prog_data), .nvm_prog_strobe(nvm_prog_strobe));

  always #2 clk = ~clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The ceiling covers the long watchdog and stop delay waits with margin.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_ctrl(input scr_ctrl_t e, input scr_ctrl_t g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("FAIL ctrl expected %h seen %h", e, g);
    end
  endtask

  function automatic scr_ctrl_t exp_ctrl();
    return '{opt_m[7], opt_m[6], opt_m[5], opt_m[3] | opt_m[2], cfg_m[7], cfg_m[4], cfg_m[3], !cfg_m[2],
      cfg_m[1], cfg_m[0], smode};
  endfunction

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] v, output logic [31:0] r,
    output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, v};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) fails++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00, rd, err);
    chk_val("prdata", e, rd);
    chk_val("pslverr", 32'h0, {31'h0, err});
  endtask

  // Protected bits follow the first write only, or every write in special mode; forced monitor never clears before reset.
  task automatic wopt(input logic [7:0] v);
    int f;
    apb(1'b1, 12'h0E4, v, rd, err);
    f = opt_m & 8'h04;
    if (smode || !lock) opt_m = v;
    else opt_m = (opt_m & 8'h37) | (v & 8'hC8);
    opt_m = opt_m | f;
    lock = 1;
  endtask

  task automatic do_reset(input bit sm, input logic [1:0] ca, input logic [7:0] nv);
    arst_n <= 1'b0;
    special_mode_pin <= sm;
    reset_cause_pin <= ca;
    nvm_cells <= nv;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    opt_m = 8'h10;
    cfg_m = nv;
    smode = sm;
    lock = 0;
    repeat (3) @(posedge clk);
    #1;
    chk_val("vector_fetch", 32'h1, {31'h0, vector_fetch});
    chk_val("ccr_masks", 32'h7, {29'h0, ccr_x_mask, ccr_i_mask, ccr_s_bit});
    chk_val("restart_vector", {16'h0, sm ? 8'hBF : 8'hFF, lo_t[ca]}, {16'h0, restart_vector});
    @(posedge clk);
    #1;
    chk_val("restart_vector", {16'h0, sm ? 8'hBF : 8'hFF, lo_t[ca] + 8'h01}, {16'h0, restart_vector});
  endtask

  task automatic stop_chk();
    int e;
    e = opt_m[4] ? 4001 : 1;
    @(posedge clk);
    stop_exit <= 1'b1;
    @(posedge clk);
    stop_exit <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (stop_recovered !== 1'b1 && n < 5000);
    chk_val("stop_cycles", e, n);
  endtask

  initial begin
    for (int i = 0; i < 6; i++) begin
      do_reset(i >= 3, 2'(i % 3), 8'($random(seed)));
      rdc(12'h0E4, 32'h10);
      rdc(12'h0FC, cfg_m | 8'h60);
      chk_ctrl(exp_ctrl(), ctrl);
      end_test("reset");
    end
    d = 8'($random(seed)) & 8'hFB;
    apb(1'b1, 12'h0FC, d, rd, err);
    cfg_m = d;
    rdc(12'h0FC, d | 8'h60);
    for (int k = 0; k < 2; k++) begin
      wopt(8'($random(seed)) & 8'hEC);
      rdc(12'h0E4, opt_m);
      chk_ctrl(exp_ctrl(), ctrl);
    end
    stop_chk();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (watchdog_tick !== 1'b1 && n < 40000);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (watchdog_tick !== 1'b1 && n < 40000);
    chk_val("watchdog_period", 32'd32768, n);
    end_test("special");
    do_reset(1'b0, 2'h0, 8'($random(seed)));
    @(posedge clk);
    cpu_ccr_release <= 1'b1;
    @(posedge clk);
    cpu_ccr_release <= 1'b0;
    #1;
    chk_val("ccr_masks", 32'h0, {29'h0, ccr_x_mask, ccr_i_mask, ccr_s_bit});
    for (int k = 0; k < 3; k++) begin
      wopt(8'($random(seed)));
      rdc(12'h0E4, opt_m);
      chk_ctrl(exp_ctrl(), ctrl);
    end
    wopt(8'(opt_m & 8'hF7));
    stop_chk();
    apb(1'b1, 12'h0FC, 8'($random(seed)), rd, err);
    rdc(12'h0FC, cfg_m | 8'h60);
    d = 8'($random(seed));
    apb(1'b1, 12'h0C4, d, rd, err);
    #1;
    chk_val("nvm_prog_data", d, nvm_prog_data);
    chk_val("nvm_prog_strobe", 32'h1, {31'h0, nvm_prog_strobe});
    apb(1'b0, 12'h000, 8'h00, rd, err);
    chk_val("unmapped_err", 32'h1, {31'h0, err});
    chk_val("unmapped_data", 32'h0, rd);
    end_test("normal");
    do_reset(1'b0, 2'h1, d);
    rdc(12'h0FC, d | 8'h60);
    // No write inside the window here, so the late write must still find the bits locked.
    repeat (70) @(posedge clk);
    lock = 1;
    wopt(8'hEF);
    rdc(12'h0E4, opt_m);
    end_test("window");
    stop_test();
  end
endmodule
`default_nettype wire
